// [ddri_defines.svh]
// timing, field and encoding constants for the ddr3 init/mode-register controller
// Overview of operation
// [RULE1] power-up: reset low at least 200 us
// [RULE2] cke low 10 ns before reset release
// [RULE3] wait 500 us after reset before cke
// [RULE4] clock stable max(10 ns, 5 tck) before cke
// [RULE5] nop registered before cke goes high
// [RULE6] cke stays high until init completes
// [RULE7] device odt high-z until cke registered
// [RULE8] odt held low through whole initialization
// [RULE9] wait txpr after cke before first mrs
// [RULE10] mrs order mr2, mr3, mr1, mr0, zqcl
// [RULE11] init mr1 write enables dll, a0 low
// [RULE12] init mr0 write resets dll, a8 high
// [RULE13] after zqcl wait tdllk and tzqinit
// [RULE14] warm reset: 100 ns, cke low, repeat
// [RULE15] every mrs writes all register fields
// [RULE16] device array survives mrs and dll reset
// [RULE17] consecutive mrs spaced by tmrd
// [RULE18] tmod before any non-mrs command
// [RULE19] runtime mrs only when device idle
// [RULE20] reserved mode-register bits written zero
// [RULE21] mr0 write recovery at least twr/tck
// [RULE22] rtt_nom during writes limited to rzq/2,4,6
`ifndef DDRI_DEFINES_SVH
`define DDRI_DEFINES_SVH

`define DDRI_CEIL(n, d)       (((n) + (d) - 1) / (d))
`define DDRI_MAX(a, b)        (((a) > (b)) ? (a) : (b))

`define DDRI_MCLK_NS          20
`define DDRI_TCK_NS           (2 * `DDRI_MCLK_NS)
`define DDRI_MCLK_PER_TCK     2
`define DDRI_CNT_W            16

`define DDRI_T_RST_PU_US      200
`define DDRI_RST_PU_CYC       `DDRI_CEIL(`DDRI_T_RST_PU_US * 1000, `DDRI_MCLK_NS)
`define DDRI_T_RST_SP_NS      100
`define DDRI_RST_SP_CYC       `DDRI_CEIL(`DDRI_T_RST_SP_NS, `DDRI_MCLK_NS)
`define DDRI_T_CKE_LEAD_NS    10
`define DDRI_CKE_LEAD_CYC     `DDRI_CEIL(`DDRI_T_CKE_LEAD_NS, `DDRI_MCLK_NS)
`define DDRI_T_CKE_WAIT_US    500
`define DDRI_CKE_WAIT_CYC     `DDRI_CEIL(`DDRI_T_CKE_WAIT_US * 1000, `DDRI_MCLK_NS)
`define DDRI_T_CK_STABLE_NS   10
`define DDRI_CK_STABLE_TCK    5
`define DDRI_CK_STABLE_CYC    `DDRI_MAX(`DDRI_CEIL(`DDRI_T_CK_STABLE_NS, `DDRI_MCLK_NS), \
                              `DDRI_CK_STABLE_TCK * `DDRI_MCLK_PER_TCK)
`define DDRI_T_XS_NS          270
`define DDRI_XPR_TCK          5
`define DDRI_XPR_CYC          `DDRI_MAX(`DDRI_CEIL(`DDRI_T_XS_NS, `DDRI_MCLK_NS), \
                              `DDRI_XPR_TCK * `DDRI_MCLK_PER_TCK)
`define DDRI_MRD_TCK          4
`define DDRI_MRD_CYC          (`DDRI_MRD_TCK * `DDRI_MCLK_PER_TCK)
`define DDRI_T_MOD_NS         15
`define DDRI_MOD_TCK          12
`define DDRI_MOD_CYC          `DDRI_MAX(`DDRI_CEIL(`DDRI_T_MOD_NS, `DDRI_MCLK_NS), \
                              `DDRI_MOD_TCK * `DDRI_MCLK_PER_TCK)
`define DDRI_DLLK_TCK         512
`define DDRI_ZQINIT_TCK       512
`define DDRI_FINAL_CYC        (`DDRI_MAX(`DDRI_DLLK_TCK, `DDRI_ZQINIT_TCK) * `DDRI_MCLK_PER_TCK)
`define DDRI_T_WR_NS          15
`define DDRI_WR_MIN           `DDRI_CEIL(`DDRI_T_WR_NS, `DDRI_TCK_NS)

// command pins {cs_n, ras_n, cas_n, we_n}
`define DDRI_CMD_NOP          4'h7
`define DDRI_CMD_MRS          4'h0
`define DDRI_CMD_ZQCL         4'h6
`define DDRI_BA_MR0           3'h0
`define DDRI_BA_MR1           3'h1
`define DDRI_INIT_ORDER       8'h1E
`define DDRI_LAST_IDX         2'h3

// bits that survive the reserved-bit mask, per mode register
`define DDRI_MR0_KEEP         16'h1FFF
`define DDRI_MR1_KEEP         16'h12FF
`define DDRI_MR2_KEEP         16'h06FF
`define DDRI_MR3_KEEP         16'h0007

`define DDRI_BIT_DLL_DIS      0
`define DDRI_BIT_DLL_RST      8
`define DDRI_BIT_ZQ_LONG      10
`define DDRI_BIT_WLEV         7
`define DDRI_BIT_QOFF         12
`define DDRI_BIT_RTT2         9
`define DDRI_BIT_RTT1         6
`define DDRI_BIT_RTT0         2
`define DDRI_RTT_MAX_WRITE    3'h3
`define DDRI_WR_LSB           9
`define DDRI_WR_W             3
`define DDRI_WR_CYC_W         5
`define DDRI_WR_LUT           40'h73148398B0

`endif

// [ddri_pkg.sv]
// types shared by the ddr3 init/mode-register controller
`default_nettype none
package ddri_pkg;
	typedef enum logic [8:0] {
		ST_RST_HOLD = 9'h001,
		ST_CKE_WAIT = 9'h002,
		ST_XPR      = 9'h004,
		ST_MRS_GAP  = 9'h008,
		ST_ZQ       = 9'h010,
		ST_ZQ_WAIT  = 9'h020,
		ST_READY    = 9'h040,
		ST_RT_GAP   = 9'h080,
		ST_CKE_DROP = 9'h100
	} ddri_state_e;
	typedef logic [3:0] ddri_cmd_t;
	typedef logic [1:0] ddri_mr_t;
endpackage
`default_nettype wire

// [ddri_ctrl.sv]
// ddr3 power-up / warm reset sequencer and mode register writer
`include "ddri_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ddri_ctrl #(
	parameter int unsigned RST_PU_CYC   = `DDRI_RST_PU_CYC,
	parameter int unsigned CKE_WAIT_CYC = `DDRI_CKE_WAIT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        start_reset,
	input  wire logic        dev_idle,
	input  wire logic        rtt_in_writes,
	input  wire logic [15:0] mr0_val,
	input  wire logic [15:0] mr1_val,
	input  wire logic [15:0] mr2_val,
	input  wire logic [15:0] mr3_val,
	input  wire logic        mrs_req,
	input  wire logic [1:0]  mrs_sel,
	input  wire logic [15:0] mrs_val,
	output var  logic        ddr_reset_n,
	output var  logic        ddr_cke,
	output var  logic        ddr_odt,
	output var  logic        ddr_ck,
	output var  logic        ddr_ck_n,
	output var  logic        ddr_cs_n,
	output var  logic        ddr_ras_n,
	output var  logic        ddr_cas_n,
	output var  logic        ddr_we_n,
	output var  logic [2:0]  ddr_ba,
	output var  logic [15:0] ddr_addr,
	output var  logic        init_done,
	output var  logic        mrs_ack,
	output var  logic        cfg_error
);

	////////////////////////////////////////////////////////////////////////////////
	// decoders shared by the init path and the runtime path

	function automatic logic [15:0] mr_clean(
		input logic [1:0]  sel,
		input logic [15:0] val,
		input logic        init
	);
		logic [15:0] v;
		v = val;
		unique case (sel)
			2'h0: v = val & `DDRI_MR0_KEEP;
			2'h1: v = val & `DDRI_MR1_KEEP;
			2'h2: v = val & `DDRI_MR2_KEEP;
			2'h3: v = val & `DDRI_MR3_KEEP;
		endcase
		// [RULE11] dll enabled at init
		if (init && sel == `DDRI_BA_MR1)
			v[`DDRI_BIT_DLL_DIS] = 1'b0;
		// [RULE12] dll reset at init
		if (init && sel == `DDRI_BA_MR0)
			v[`DDRI_BIT_DLL_RST] = 1'b1;
		return v;
	endfunction

	function automatic logic mr_ok(
		input logic [1:0]  sel,
		input logic [15:0] val,
		input logic        rtt_w
	);
		logic [2:0]                rtt;
		logic [`DDRI_WR_W-1:0]     wr_code;
		logic [`DDRI_WR_CYC_W-1:0] wr_cyc;
		logic                      limit;
		rtt     = {val[`DDRI_BIT_RTT2], val[`DDRI_BIT_RTT1], val[`DDRI_BIT_RTT0]};
		wr_code = val[`DDRI_WR_LSB +: `DDRI_WR_W];
		wr_cyc  = `DDRI_WR_CYC_W'(`DDRI_WR_LUT >> (wr_code * `DDRI_WR_CYC_W));
		// write leveling with qoff lifts the termination limit
		limit   = val[`DDRI_BIT_WLEV] ? !val[`DDRI_BIT_QOFF] : rtt_w;
		mr_ok   = 1'b1;
		// [RULE21] write recovery floor
		if (sel == `DDRI_BA_MR0 && wr_cyc < `DDRI_WR_CYC_W'(`DDRI_WR_MIN))
			mr_ok = 1'b0;
		// [RULE22] termination limit
		if (sel == `DDRI_BA_MR1 && limit && rtt > `DDRI_RTT_MAX_WRITE)
			mr_ok = 1'b0;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	ddri_pkg::ddri_state_e    state;
	ddri_pkg::ddri_state_e    next_state;
	logic [`DDRI_CNT_W-1:0]   cnt;
	logic [`DDRI_CNT_W-1:0]   next_cnt;
	ddri_pkg::ddri_mr_t       idx;
	ddri_pkg::ddri_mr_t       next_idx;
	ddri_pkg::ddri_cmd_t      next_cmd;
	logic [2:0]               next_ba;
	logic [15:0]              next_addr;
	logic                     next_cke;
	logic                     next_reset_n;
	logic                     next_ck_run;
	logic                     next_done;
	logic                     next_ack;
	logic                     ck_run;
	logic                     slot;
	logic                     expired;
	logic [15:0]              mr_set [4];
	ddri_pkg::ddri_mr_t       sel_i;
	logic [15:0]              val_i;

	assign mr_set[0] = mr0_val;
	assign mr_set[1] = mr1_val;
	assign mr_set[2] = mr2_val;
	assign mr_set[3] = mr3_val;
	// commands change as ck falls, so each one is centred on a rising edge
	assign slot      = ddr_ck;
	assign expired   = (cnt == '0);
	assign sel_i     = ddri_pkg::ddri_mr_t'(`DDRI_INIT_ORDER >> ({1'b0, idx} << 1));
	assign val_i     = mr_clean(sel_i, mr_set[sel_i], 1'b1);

	always_comb
	begin
		next_state   = state;
		next_cnt     = expired ? cnt : cnt - 1'b1;
		next_idx     = idx;
		next_cmd     = slot ? `DDRI_CMD_NOP : {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
		next_ba      = ddr_ba;
		next_addr    = ddr_addr;
		next_cke     = ddr_cke;
		next_reset_n = ddr_reset_n;
		next_ck_run  = ck_run;
		next_done    = init_done;
		next_ack     = 1'b0;
		unique case (state)
			ddri_pkg::ST_CKE_DROP:
			begin
				// [RULE14] cke low before reset
				// [RULE2] cke leads reset release
				next_cke  = 1'b0;
				next_done = 1'b0;
				if (expired)
				begin
					next_state   = ddri_pkg::ST_RST_HOLD;
					next_reset_n = 1'b0;
					next_ck_run  = 1'b0;
					next_cnt     = `DDRI_CNT_W'(`DDRI_RST_SP_CYC);
				end
			end
			ddri_pkg::ST_RST_HOLD:
			begin
				// [RULE1] hold reset low
				if (expired)
				begin
					next_state   = ddri_pkg::ST_CKE_WAIT;
					next_reset_n = 1'b1;
					next_ck_run  = 1'b1;
					next_cnt     = `DDRI_CNT_W'(CKE_WAIT_CYC);
				end
			end
			ddri_pkg::ST_CKE_WAIT:
			begin
				// [RULE3] 500 us before cke
				if (expired && slot)
				begin
					// [RULE5] nop under cke rise
					next_cmd   = `DDRI_CMD_NOP;
					next_cke   = 1'b1;
					next_state = ddri_pkg::ST_XPR;
					next_cnt   = `DDRI_CNT_W'(`DDRI_XPR_CYC);
					next_idx   = '0;
				end
			end
			ddri_pkg::ST_XPR, ddri_pkg::ST_MRS_GAP:
			begin
				// [RULE9] txpr then mrs
				if (expired && slot && mr_ok(sel_i, val_i, rtt_in_writes))
				begin
					// [RULE10] programmed order
					next_cmd   = `DDRI_CMD_MRS;
					next_ba    = {1'b0, sel_i};
					// [RULE15] full register value
					next_addr  = val_i;
					next_state = (idx == `DDRI_LAST_IDX) ? ddri_pkg::ST_ZQ : ddri_pkg::ST_MRS_GAP;
					// [RULE17] tmrd between mrs
					next_cnt   = (idx == `DDRI_LAST_IDX) ? `DDRI_CNT_W'(`DDRI_MOD_CYC)
					                                     : `DDRI_CNT_W'(`DDRI_MRD_CYC);
					next_idx   = idx + 1'b1;
				end
			end
			ddri_pkg::ST_ZQ:
			begin
				// [RULE18] tmod before zqcl
				if (expired && slot)
				begin
					next_cmd   = `DDRI_CMD_ZQCL;
					next_ba    = '0;
					next_addr  = 16'h0000;
					next_addr[`DDRI_BIT_ZQ_LONG] = 1'b1;
					next_state = ddri_pkg::ST_ZQ_WAIT;
					next_cnt   = `DDRI_CNT_W'(`DDRI_FINAL_CYC);
				end
			end
			ddri_pkg::ST_ZQ_WAIT:
			begin
				// [RULE13] dll lock and zq wait
				if (expired)
				begin
					next_state = ddri_pkg::ST_READY;
					next_done  = 1'b1;
				end
			end
			ddri_pkg::ST_READY:
			begin
				if (start_reset)
				begin
					next_state = ddri_pkg::ST_CKE_DROP;
					next_cnt   = `DDRI_CNT_W'(`DDRI_CKE_LEAD_CYC);
				end
				// [RULE19] idle-only rewrite
				else if (mrs_req && dev_idle && slot && mr_ok(mrs_sel, mrs_val, rtt_in_writes))
				begin
					next_cmd   = `DDRI_CMD_MRS;
					next_ba    = {1'b0, mrs_sel};
					// [RULE20] reserved bits zero
					next_addr  = mr_clean(mrs_sel, mrs_val, 1'b0);
					next_ack   = 1'b1;
					next_state = ddri_pkg::ST_RT_GAP;
					// tmod covers tmrd too, so one wait serves both
					next_cnt   = `DDRI_CNT_W'(`DDRI_MOD_CYC);
				end
			end
			ddri_pkg::ST_RT_GAP:
			begin
				if (expired)
					next_state = ddri_pkg::ST_READY;
			end
			default:
			begin
				next_state = ddri_pkg::ST_CKE_DROP;
				next_cnt   = `DDRI_CNT_W'(`DDRI_CKE_LEAD_CYC);
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ddri_pkg::ST_RST_HOLD;
			cnt   <= `DDRI_CNT_W'(RST_PU_CYC);
			idx   <= '0;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
			idx   <= next_idx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pins toward the device

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ddr_reset_n <= 1'b0;
			ddr_cke     <= 1'b0;
			ck_run      <= 1'b0;
		end
		else
		begin
			ddr_reset_n <= next_reset_n;
			// [RULE6] cke held high
			ddr_cke     <= next_cke;
			ck_run      <= next_ck_run;
		end
	end

	// [RULE8] odt kept low
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			ddr_odt <= 1'b0;
		else
			ddr_odt <= 1'b0;
	end

	// ck is mclk halved; it stops during reset hold where the device ignores it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ddr_ck   <= 1'b0;
			ddr_ck_n <= 1'b1;
		end
		else
		begin
			// [RULE4] clock runs before cke
			ddr_ck   <= ck_run & ~ddr_ck;
			ddr_ck_n <= ~(ck_run & ~ddr_ck);
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= `DDRI_CMD_NOP;
			ddr_ba   <= '0;
			ddr_addr <= '0;
		end
		else
		begin
			{ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= next_cmd;
			ddr_ba   <= next_ba;
			ddr_addr <= next_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// user-side status

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			init_done <= 1'b0;
			mrs_ack   <= 1'b0;
			cfg_error <= 1'b0;
		end
		else
		begin
			init_done <= next_done;
			mrs_ack   <= next_ack;
			cfg_error <= !mr_ok(2'h0, mr_clean(2'h0, mr0_val, 1'b1), rtt_in_writes)
			           || !mr_ok(2'h1, mr_clean(2'h1, mr1_val, 1'b1), rtt_in_writes)
			           || (mrs_req && !mr_ok(mrs_sel, mrs_val, rtt_in_writes));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic [`DDRI_CNT_W-1:0] low_cnt;
	logic [`DDRI_CNT_W-1:0] high_cnt;
	logic [`DDRI_CNT_W-1:0] since_cmd;
	logic [`DDRI_CNT_W-1:0] ck_cnt;
	logic                   warm;
	logic                   cmd_new;
	logic [2:0]             last_ba;

	assign cmd_new = ({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} != `DDRI_CMD_NOP);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			low_cnt   <= '0;
			high_cnt  <= '0;
			since_cmd <= '0;
			ck_cnt    <= '0;
			warm      <= 1'b0;
			last_ba   <= '0;
		end
		else
		begin
			low_cnt   <= ddr_reset_n ? '0 : low_cnt + (&low_cnt ? 1'b0 : 1'b1);
			high_cnt  <= !ddr_reset_n ? '0 : high_cnt + (&high_cnt ? 1'b0 : 1'b1);
			ck_cnt    <= !ck_run ? '0 : ck_cnt + (&ck_cnt ? 1'b0 : 1'b1);
			since_cmd <= (next_cmd != `DDRI_CMD_NOP && !cmd_new) || (next_cke && !ddr_cke)
			           ? '0 : since_cmd + (&since_cmd ? 1'b0 : 1'b1);
			if (state == ddri_pkg::ST_CKE_DROP)
				warm <= 1'b1;
			if (cmd_new && !ddr_ras_n == 1'b1)
				last_ba <= ddr_ba;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_rst_len;
		$rose(ddr_reset_n) |-> $past(low_cnt) >= (warm ? `DDRI_RST_SP_CYC : RST_PU_CYC);
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset released too early"); // [RULE1]

	property p_cke_lead;
		$rose(ddr_reset_n) |-> !ddr_cke && !$past(ddr_cke, 2);
	endproperty
	a_cke_lead: assert property (p_cke_lead) else $error("cke not low before reset"); // [RULE2]

	property p_cke_wait;
		$rose(ddr_cke) |-> $past(high_cnt) >= CKE_WAIT_CYC && ck_cnt > `DDRI_CK_STABLE_CYC;
	endproperty
	a_cke_wait: assert property (p_cke_wait) else $error("cke raised too early"); // [RULE3]

	property p_cke_nop;
		$rose(ddr_cke) |-> {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == `DDRI_CMD_NOP;
	endproperty
	a_cke_nop: assert property (p_cke_nop) else $error("no nop under cke rise"); // [RULE5]

	property p_cke_hold;
		$fell(ddr_cke) |-> $past(init_done);
	endproperty
	a_cke_hold: assert property (p_cke_hold) else $error("cke dropped during init"); // [RULE6]

	property p_odt_low;
		!init_done |-> !ddr_odt;
	endproperty
	a_odt_low: assert property (p_odt_low) else $error("odt active during init"); // [RULE8]

	property p_mrd;
		$rose(cmd_new) && !ddr_ras_n && !ddr_we_n |-> $past(since_cmd) >= `DDRI_MRD_CYC - 1;
	endproperty
	a_mrd: assert property (p_mrd) else $error("mrs spacing short"); // [RULE17]

	property p_mod;
		$rose(cmd_new) && ddr_ras_n |-> $past(since_cmd) >= `DDRI_MOD_CYC - 1
		                                 && last_ba == `DDRI_BA_MR0;
	endproperty
	a_mod: assert property (p_mod) else $error("zqcl too soon or out of order"); // [RULE18]

	property p_dll_bits;
		$rose(cmd_new) && !ddr_ras_n && !init_done |->
			(ddr_ba != `DDRI_BA_MR1 || !ddr_addr[`DDRI_BIT_DLL_DIS])
			&& (ddr_ba != `DDRI_BA_MR0 || ddr_addr[`DDRI_BIT_DLL_RST]);
	endproperty
	a_dll_bits: assert property (p_dll_bits) else $error("init dll bits wrong"); // [RULE11]

	property p_rsvd;
		$rose(cmd_new) && !ddr_ras_n |-> ddr_addr[15:13] == 3'h0 && !ddr_ba[2];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // [RULE20]

	property p_final;
		$rose(init_done) |-> $past(since_cmd) >= `DDRI_FINAL_CYC;
	endproperty
	a_final: assert property (p_final) else $error("ready before dll and zq wait"); // [RULE13]

	property p_idle;
		$rose(cmd_new) && !ddr_ras_n && init_done |-> $past(dev_idle);
	endproperty
	a_idle: assert property (p_idle) else $error("runtime mrs while busy"); // [RULE19]

endmodule
`default_nettype wire

// [ddri_ctrl_note_end.sv]
`timescale 1ns/1ps

// [ddri_dev_model.sv]
// behavioural ddr3 device: logs commands and timing marks for the bench
`include "ddri_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ddri_dev_model (
	input wire logic        reset_n,
	input wire logic        cke,
	input wire logic        ck,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [2:0]  ba,
	input wire logic [15:0] addr
);
	logic [3:0]  cmd;
	logic        cke_reg = 1'b0;
	logic        rtt_hiz;
	logic [3:0]  cmd_pre;
	logic        cke_at_rise;
	logic        cke_at_fall;
	int          ck_pre = 0;
	int          ev_n = 0;
	logic [3:0]  ev_cmd [32];
	logic [2:0]  ev_ba [32];
	logic [15:0] ev_addr [32];
	realtime     ev_t [32];
	realtime     t_rst_fall = 0.0;
	realtime     t_rst_rise;
	realtime     t_cke_low = 0.0;
	realtime     t_cke_hi;
	logic [15:0] mr [4];
	logic [7:0]  cells [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	////////////////////////////////////////////////////////////////
	// termination high-z while reset is low or until cke is registered
	assign rtt_hiz = !reset_n || !cke_reg;
	always @(negedge reset_n)
	begin
		t_rst_fall = $realtime;
		cke_at_fall = cke;
		cke_reg = 1'b0;
		ev_n = 0;
		ck_pre = 0;
		for (int i = 0; i < 4; i++)
			mr[i] = 'x;
	end
	always @(posedge reset_n)
	begin
		t_rst_rise = $realtime;
		cke_at_rise = cke;
	end
	always @(negedge cke)
		t_cke_low = $realtime;
	always @(posedge ck)
	begin
		if (reset_n === 1'b1 && !cke_reg)
		begin
			if (cke === 1'b1)
			begin
				cke_reg = 1'b1;
				t_cke_hi = $realtime;
			end
			else
			begin
				ck_pre++;
				cmd_pre = cmd;
			end
		end
		else if (reset_n === 1'b1 && ev_n < 32 &&
			(cmd === `DDRI_CMD_MRS || cmd === `DDRI_CMD_ZQCL))
		begin
			ev_cmd[ev_n] = cmd;
			ev_ba[ev_n] = ba;
			ev_addr[ev_n] = addr;
			ev_t[ev_n] = $realtime;
			if (cmd === `DDRI_CMD_MRS)
				mr[ba[1:0]] = addr;
			ev_n++;
		end
	end
endmodule
`default_nettype wire

// [ddr3_init_and_mode_register_setup_bench.sv]
// bench for the ddr3 init and mode register controller
`include "ddri_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ddr3_init_and_mode_register_setup_bench;
	localparam int PU = 20;
	localparam int CW = 30;
	localparam real CYC = 20.0;
	localparam logic [2:0] ORD [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
	localparam logic [15:0] RV [4] = '{16'h0200, 16'h0284, 16'h1280, 16'h0244};
	localparam logic RW [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
	localparam logic RK [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic        mclk;
	logic        arst_n;
	logic        start_reset;
	logic        dev_idle;
	logic        rtt_in_writes;
	logic [15:0] mr0_val;
	logic [15:0] mr1_val;
	logic [15:0] mr2_val;
	logic [15:0] mr3_val;
	logic        mrs_req;
	logic [1:0]  mrs_sel;
	logic [15:0] mrs_val;
	logic        ddr_reset_n;
	logic        ddr_cke;
	logic        ddr_odt;
	logic        ddr_ck;
	logic        ddr_cs_n;
	logic        ddr_ras_n;
	logic        ddr_cas_n;
	logic        ddr_we_n;
	logic [2:0]  ddr_ba;
	logic [15:0] ddr_addr;
	logic        init_done;
	logic        mrs_ack;
	logic        cfg_error;
	logic        warm;
	int          num_errors = 0;
	int          total_checks = 0;
	int          bad_cke = 0;
	int          bad_odt = 0;
	realtime     t_done;

	ddri_ctrl #(.RST_PU_CYC(PU), .CKE_WAIT_CYC(CW)) dut_u (
		.mclk(mclk), .arst_n(arst_n), .start_reset(start_reset), .dev_idle(dev_idle),
		.rtt_in_writes(rtt_in_writes), .mr0_val(mr0_val), .mr1_val(mr1_val),
		.mr2_val(mr2_val), .mr3_val(mr3_val), .mrs_req(mrs_req), .mrs_sel(mrs_sel),
		.mrs_val(mrs_val), .ddr_reset_n(ddr_reset_n), .ddr_cke(ddr_cke), .ddr_odt(ddr_odt),
		.ddr_ck(ddr_ck), .ddr_ck_n(), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
		.ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
		.init_done(init_done), .mrs_ack(mrs_ack), .cfg_error(cfg_error));
	ddri_dev_model model_u (
		.reset_n(ddr_reset_n), .cke(ddr_cke), .ck(ddr_ck), .cs_n(ddr_cs_n),
		.ras_n(ddr_ras_n), .cas_n(ddr_cas_n), .we_n(ddr_we_n), .ba(ddr_ba), .addr(ddr_addr));
	////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// warm reset legally drops cke, so the watch pauses then
	always @(negedge mclk)
		if (arst_n && !warm && model_u.cke_reg && init_done !== 1'b1)
		begin
			if (ddr_cke !== 1'b1)
				bad_cke++;
			if (ddr_odt !== 1'b0)
				bad_odt++;
		end
	always @(posedge init_done)
		t_done = $realtime;
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic fail(input string s);
		num_errors++;
		$display("wrong value at %0t: %s", $time, s);
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string s);
		total_checks++;
		if (got !== exp)
			fail(s);
	endtask
	task automatic chk_time(input real got, input real lo, input string s);
		total_checks++;
		if (!(got >= lo))
			fail(s);
	endtask
	task automatic wait_on(input int w, input logic lvl);
		logic v;
		for (int n = 0; n < 5000; n++)
		begin
			@(negedge mclk);
			v = (w == 0) ? init_done : ddr_reset_n;
			if (v === lvl)
				return;
		end
		fail("timeout");
		end_sim();
	endtask
	function automatic logic [15:0] keep(input logic [1:0] s);
		case (s)
			2'h0: return `DDRI_MR0_KEEP;
			2'h1: return `DDRI_MR1_KEEP;
			2'h2: return `DDRI_MR2_KEEP;
			default: return `DDRI_MR3_KEEP;
		endcase
	endfunction
	function automatic logic [15:0] init_exp(input logic [1:0] s);
		logic [15:0] v;
		v = (s == 2'h0) ? mr0_val : (s == 2'h1) ? mr1_val : (s == 2'h2) ? mr2_val : mr3_val;
		v = v & keep(s);
		if (s == 2'h1)
			v[0] = 1'b0;
		if (s == 2'h0)
			v[8] = 1'b1;
		return v;
	endfunction
	task automatic mrs_try(input logic [1:0] s, input logic [15:0] v, output logic got,
		output logic err);
		@(negedge mclk);
		mrs_req = 1'b1;
		mrs_sel = s;
		mrs_val = v;
		got = 1'b0;
		for (int n = 0; n < 60 && got !== 1'b1; n++)
		begin
			@(negedge mclk);
			got = mrs_ack;
			err = cfg_error;
		end
		mrs_req = 1'b0;
		@(negedge mclk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic check_init(input bit pu);
		logic [1:0] s;
		wait_on(0, 1'b1);
		if (pu)
			chk_time(model_u.t_rst_rise - model_u.t_rst_fall, PU * CYC, "pu reset");
		else
			chk_time(model_u.t_rst_rise - model_u.t_rst_fall, 100.0, "warm reset");
		chk_val(16'(model_u.cke_at_rise), 16'h0, "cke at release");
		chk_time(model_u.t_rst_rise - model_u.t_cke_low, 10.0, "cke lead");
		chk_time(model_u.t_cke_hi - model_u.t_rst_rise, CW * CYC, "cke wait");
		chk_time(model_u.ck_pre, 5.0, "ck before cke");
		chk_val(16'(model_u.cmd_pre), 16'(`DDRI_CMD_NOP), "nop before cke");
		chk_val(16'(model_u.ev_n), 16'h5, "command count");
		chk_time(model_u.ev_t[0] - model_u.t_cke_hi, 270.0, "txpr");
		for (int i = 0; i < 4; i++)
		begin
			s = ORD[i][1:0];
			chk_val(16'(model_u.ev_cmd[i]), 16'(`DDRI_CMD_MRS), "mrs");
			chk_val(16'(model_u.ev_ba[i]), 16'(ORD[i]), "mrs order");
			chk_val(model_u.ev_addr[i], init_exp(s), "mrs value");
			chk_val(model_u.ev_addr[i] & ~keep(s), 16'h0, "reserved");
			if (i > 0)
				chk_time(model_u.ev_t[i] - model_u.ev_t[i - 1], 160.0, "tmrd");
		end
		chk_val(16'(model_u.ev_addr[2][0]), 16'h0, "dll enable");
		chk_val(16'(model_u.ev_addr[3][8]), 16'h1, "dll reset");
		chk_val(16'(model_u.ev_cmd[4]), 16'(`DDRI_CMD_ZQCL), "zqcl");
		chk_val(16'(model_u.ev_addr[4][10]), 16'h1, "zq long");
		chk_time(model_u.ev_t[4] - model_u.ev_t[3], 480.0, "tmod");
		chk_time(t_done - model_u.ev_t[4], 512 * 40.0, "final wait");
		chk_val(16'(bad_cke), 16'h0, "cke dropped");
		chk_val(16'(bad_odt), 16'h0, "odt raised");
	endtask
	task automatic check_runtime();
		int k;
		logic got;
		logic err;
		dev_idle = 1'b0;
		k = model_u.ev_n;
		mrs_try(2'h2, 16'h0008, got, err);
		chk_val(16'(got), 16'h0, "served busy");
		chk_val(16'(model_u.ev_n), 16'(k), "mrs while busy");
		dev_idle = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			mrs_try(i[1:0], 16'hFD7B, got, err);
			k = model_u.ev_n - 1;
			chk_val(16'(got), 16'h1, "no ack");
			chk_val(16'(model_u.ev_ba[k]), 16'(i), "runtime ba");
			chk_val(model_u.mr[i], 16'hFD7B & keep(i[1:0]), "runtime value");
			chk_time(model_u.ev_t[k] - model_u.ev_t[k - 1], 160.0, "runtime gap");
		end
		for (int i = 0; i < 4; i++)
		begin
			rtt_in_writes = RW[i];
			mrs_try(2'h1, RV[i], got, err);
			chk_val(16'(got), 16'(RK[i]), "rtt accept");
			chk_val(16'(err), 16'(!RK[i]), "rtt error");
		end
		rtt_in_writes = 1'b1;
	endtask
	task automatic check_warm();
		@(negedge mclk);
		start_reset = 1'b1;
		warm = 1'b1;
		// a request is only taken once a runtime mrs gap is over, so hold it until cke drops
		for (int n = 0; n < 60 && ddr_cke === 1'b1; n++)
			@(negedge mclk);
		start_reset = 1'b0;
		wait_on(1, 1'b0);
		chk_val(16'(model_u.cke_at_fall), 16'h0, "cke at warm reset");
		chk_val(16'(model_u.rtt_hiz), 16'h1, "odt not high-z in reset");
		wait_on(1, 1'b1);
		warm = 1'b0;
		chk_val(16'(init_done), 16'h0, "still ready");
		check_init(1'b0);
		chk_val(16'(model_u.cells[2]), 16'h00C3, "array changed");
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		arst_n = 1'b0;
		start_reset = 1'b0;
		dev_idle = 1'b1;
		rtt_in_writes = 1'b1;
		mr0_val = 16'hE2F4;
		mr1_val = 16'hFD05;
		mr2_val = 16'hFFFF;
		mr3_val = 16'hFFFF;
		mrs_req = 1'b0;
		mrs_sel = 2'h0;
		mrs_val = 16'h0;
		warm = 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		check_init(1'b1);
		check_runtime();
		check_warm();
		end_sim();
	end
endmodule
`default_nettype wire
